// ==== iepc_top.sv ====
// iepc_top: quadrature position counter with homing, compare outputs
// and frequency measurement, registers on AHB-Lite.
// assumes a single AHB-Lite master; encoder pins are asynchronous.
// Operation
// - quadruple A/B decoding, one count per edge
// - configurable digital input filter suppresses fast pulses
// - option: zero mark ignored or loads start
// - high limit 2147483647 linear, programmable modulo
// - low limit -2147483648 linear, zero modulo
// - past a limit, wrap to opposite limit
// - start value is initial and homing position
// - opening gate resumes from current value
// - reference edge arms, next zero mark loads
// - reference alone loads directly; unused otherwise
// - edge selectable; sync once, needs re-arm
// - first output: program-driven, or set-until-compare-0
// - second output: set until compare value 1
// - compare both directions; substitute zero on stop
// - frequency refreshed every update time
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iepc_top #(
  parameter int unsigned MS_CYC = iepc_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output wire logic        hreadyout,
  output wire logic        hresp,
  // encoder and digital inputs
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_n,
  input  wire logic        reference_input,
  input  wire logic        spare_input_one,
  input  wire logic        spare_input_two,
  // compare outputs
  output var  logic        first_compare_output,
  output var  logic        second_compare_output
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [9:0]  ctrl;
  logic [15:0] filt_lim;
  logic [31:0] start_val;
  logic [31:0] high_val;
  logic [31:0] cmp0;
  logic [31:0] cmp1;
  logic [7:0]  upd_ms;
  logic [31:0] pos;
  logic [31:0] freq;
  logic        armed;
  logic        pend;
  logic        latch1;
  logic        latch2;
  logic        dir_up;
  logic        a_prev;
  logic        b_prev;
  logic        n_prev;
  logic        r_prev;
  // ----------------------------------------------------------------
  // input filters
  // ----------------------------------------------------------------
  logic [5:0]  pins_f;
  wire  [5:0]  pins = {spare_input_two, spare_input_one, reference_input,
                       enc_n, enc_b, enc_a};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_filt
      iepc_filter u_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw     (pins[gi]),
        .limit   (filt_lim),
        .filt    (pins_f[gi])
      );
    end
  endgenerate

  wire a_f = pins_f[0];
  wire b_f = pins_f[1];
  wire n_f = pins_f[2];
  wire r_f = pins_f[3];
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic       dp_wr;
  logic [7:0] dp_addr;
  wire        ap_valid = hsel && htrans[1] && hready;
  wire  [7:0] ap_addr  = haddr[7:0];
  wire        wr_ctrl  = dp_wr && dp_addr == iepc_pkg::A_CTRL;
  wire        wr_cmd   = dp_wr && dp_addr == iepc_pkg::A_CMD;
  wire        wr_filt  = dp_wr && dp_addr == iepc_pkg::A_FILT;
  wire        wr_start = dp_wr && dp_addr == iepc_pkg::A_START;
  wire        wr_high  = dp_wr && dp_addr == iepc_pkg::A_HIGH;
  wire        wr_cmp0  = dp_wr && dp_addr == iepc_pkg::A_CMP0;
  wire        wr_cmp1  = dp_wr && dp_addr == iepc_pkg::A_CMP1;
  wire        wr_upd   = dp_wr && dp_addr == iepc_pkg::A_UPD;
  wire        cmd_set1 = wr_cmd && hwdata[iepc_pkg::K_SET1];
  wire        cmd_set2 = wr_cmd && hwdata[iepc_pkg::K_SET2];
  wire        cmd_arm  = wr_cmd && hwdata[iepc_pkg::K_ARM];
  wire  [7:0] upd_clip = hwdata[7:0] > iepc_pkg::UPD_MAX ? iepc_pkg::UPD_MAX
                                                         : hwdata[7:0];
  wire  [31:0] stat    = {25'h0000000, dir_up, pins_f[5], pins_f[4], pend,
                          armed, second_compare_output, first_compare_output};
  logic [31:0] rdata;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    unique case (ap_addr)
      iepc_pkg::A_CTRL:  rdata = {22'h000000, ctrl};
      iepc_pkg::A_FILT:  rdata = {16'h0000, filt_lim};
      iepc_pkg::A_START: rdata = start_val;
      iepc_pkg::A_HIGH:  rdata = high_val;
      iepc_pkg::A_CMP0:  rdata = cmp0;
      iepc_pkg::A_CMP1:  rdata = cmp1;
      iepc_pkg::A_UPD:   rdata = {24'h000000, upd_ms};
      iepc_pkg::A_POS:   rdata = pos;
      iepc_pkg::A_STAT:  rdata = stat;
      iepc_pkg::A_FREQ:  rdata = freq;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      dp_wr   <= ap_valid && hwrite;
      dp_addr <= ap_addr;
      if (ap_valid && !hwrite) hrdata <= rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl      <= iepc_pkg::CTRL_RST;
      filt_lim  <= iepc_pkg::FILT_RST;
      start_val <= iepc_pkg::START_RST;
      high_val  <= iepc_pkg::LIN_HIGH;
      cmp0      <= iepc_pkg::CMP0_RST;
      cmp1      <= iepc_pkg::CMP1_RST;
      upd_ms    <= iepc_pkg::UPD_RST;
    end else begin
      if (wr_ctrl)  ctrl      <= hwdata[9:0];
      if (wr_filt)  filt_lim  <= hwdata[15:0];
      if (wr_start) start_val <= hwdata;
      if (wr_high)  high_val  <= hwdata;
      if (wr_cmp0)  cmp0      <= hwdata;
      if (wr_cmp1)  cmp1      <= hwdata;
      if (wr_upd)   upd_ms    <= upd_clip;
    end
  end
  // ----------------------------------------------------------------
  // quadrature decode
  // ----------------------------------------------------------------
  wire gate    = ctrl[iepc_pkg::C_GATE];
  wire modulo  = ctrl[iepc_pkg::C_MOD];
  wire use_n   = ctrl[iepc_pkg::C_USEN];
  wire ext_ref = ctrl[iepc_pkg::C_EXTREF];
  wire fall    = ctrl[iepc_pkg::C_FALL];
  wire cpu_ok  = ctrl[iepc_pkg::C_CPUOK];
  wire [1:0] mode1 = ctrl[iepc_pkg::C_MODE +: 2];
  wire user1   = ctrl[iepc_pkg::C_USER1];
  // both tracks moving at once is a lost edge and is dropped
  wire one_edge = (a_f ^ a_prev) ^ (b_f ^ b_prev);
  wire step_up  = one_edge && (a_f ^ b_prev);
  wire step_dn  = one_edge && !(a_f ^ b_prev);
  wire [31:0] hi_lim = modulo ? high_val : iepc_pkg::LIN_HIGH;
  wire [31:0] lo_lim = modulo ? iepc_pkg::MOD_LOW : iepc_pkg::LIN_LOW;
  wire [31:0] inc_val = pos == hi_lim ? lo_lim : pos + 32'h0000_0001;
  wire [31:0] dec_val = pos == lo_lim ? hi_lim : pos - 32'h0000_0001;
  // ----------------------------------------------------------------
  // homing
  // ----------------------------------------------------------------
  wire n_rise  = n_f && !n_prev;
  wire r_edge  = fall ? (r_prev && !r_f) : (!r_prev && r_f);
  wire ref_arm = ext_ref && use_n && armed && r_edge;
  wire ld_refn = ext_ref && use_n && pend && n_rise;
  wire ld_ref  = ext_ref && !use_n && armed && r_edge;
  wire ld_n    = !ext_ref && use_n && armed && n_rise;
  wire home    = ld_refn || ld_ref || ld_n;
  wire count   = gate && (step_up || step_dn);

  wire [31:0] next_pos = home ? start_val :
                         !count ? pos :
                         step_up ? inc_val : dec_val;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_prev <= 1'b0;
      b_prev <= 1'b0;
      n_prev <= 1'b0;
      r_prev <= 1'b0;
      dir_up <= 1'b1;
    end else begin
      a_prev <= a_f;
      b_prev <= b_f;
      n_prev <= n_f;
      r_prev <= r_f;
      if (count) dir_up <= step_up;
    end
  end

  // pos resets to the reset value of start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pos <= iepc_pkg::START_RST;
    else pos <= next_pos;
  end

  // re-arm wins over a homing in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b1;
      pend  <= 1'b0;
    end else begin
      if (cmd_arm) armed <= 1'b1;
      else if (home) armed <= 1'b0;
      if (ld_refn || cmd_arm || !(ext_ref && use_n)) pend <= 1'b0;
      else if (ref_arm) pend <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // compare outputs
  // ----------------------------------------------------------------
  wire hit0 = next_pos == cmp0 && next_pos != pos;
  wire hit1 = next_pos == cmp1 && next_pos != pos;
  wire next_latch1 = cmd_set1 || (latch1 && !hit0);
  wire next_latch2 = cmd_set2 || (latch2 && !hit1);
  wire next_out1 = cpu_ok && (mode1 == iepc_pkg::MODE_CMP ? next_latch1 : user1);
  wire next_out2 = cpu_ok && next_latch2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch1                <= 1'b0;
      latch2                <= 1'b0;
      first_compare_output  <= 1'b0;
      second_compare_output <= 1'b0;
    end else begin
      latch1                <= next_latch1;
      latch2                <= next_latch2;
      first_compare_output  <= next_out1;
      second_compare_output <= next_out2;
    end
  end
  // ----------------------------------------------------------------
  // frequency
  // ----------------------------------------------------------------
  iepc_freq #(.MS_CYC(MS_CYC)) u_freq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .step    (count),
    .up      (step_up),
    .upd_ms  (upd_ms),
    .freq    (freq)
  );
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_up_mid;
    count && !home && step_up && pos != hi_lim;
  endsequence
  sequence s_dn_mid;
    count && !home && step_dn && pos != lo_lim;
  endsequence
  sequence s_ref_then_n;
    ext_ref && use_n && pend ##0 n_rise;
  endsequence

  count_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_up_mid |=> pos == $past(pos) + 32'h0000_0001)
    else $error("up step did not add one");
  lin_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count && !home && !modulo && step_up && pos == 32'h7FFF_FFFF |=> pos == 32'h8000_0000)
    else $error("linear high limit did not wrap");
  mod_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count && !home && modulo && step_dn && pos == 32'h0 |=> pos == $past(high_val))
    else $error("modulo low limit did not wrap");
  gate_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !gate && !home |=> $stable(pos))
    else $error("count moved with gate closed");
  home_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    home |=> pos == $past(start_val) && (!armed || $past(cmd_arm)))
    else $error("homing did not load start value");
  ref_n_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_ref_then_n |=> pos == $past(start_val))
    else $error("armed zero mark did not load");
  sync_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
    home && !cmd_arm |=> !armed && !home)
    else $error("synchronization repeated without re-arm");
  cmp1_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    latch2 && hit1 && !cmd_set2 |=> !latch2 && !second_compare_output)
    else $error("second output not cleared at compare value");
  subst_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cpu_ok |=> !first_compare_output && !second_compare_output)
    else $error("substitute value not applied");
  count_dn_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dn_mid |=> pos == $past(pos) - 32'h0000_0001)
    else $error("down step did not subtract one");
  pos_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !count && !home |=> $stable(pos))
    else $error("count moved without a step or homing");
  dir_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    count |=> dir_up == $past(step_up))
    else $error("direction bit did not follow the step");
  ref_direct_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_ref && !use_n && armed && r_edge |=> pos == $past(start_val))
    else $error("reference edge did not load start value");
  // ----------------------------------------------------------------
  // compare output checks
  // ----------------------------------------------------------------
  cmp0_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mode1 == iepc_pkg::MODE_CMP && latch1 && hit0 && !cmd_set1
    |=> !latch1 && !first_compare_output)
    else $error("first output not cleared at compare value");
  set1_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_set1 && cpu_ok && mode1 == iepc_pkg::MODE_CMP |=> first_compare_output)
    else $error("first output not set by command");
  set2_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_set2 && cpu_ok |=> latch2 && second_compare_output)
    else $error("second output not set by command");
  user_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cpu_ok && mode1 != iepc_pkg::MODE_CMP |=> first_compare_output == $past(user1))
    else $error("first output does not follow user value");
endmodule : iepc_top
`default_nettype wire

// ==== iepc_pkg.sv ====
// iepc_pkg: constants of the incremental encoder position counter.
// assumes a 200 MHz hclk and a 32-bit AHB-Lite register bus.
package iepc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned FILT_FREQ_HZ = 200_000;
  localparam int unsigned FILT_CYC     = CLK_HZ / (2 * FILT_FREQ_HZ);
  localparam int unsigned UPD_MS       = 10;
  localparam int unsigned UPD_MS_MAX   = 100;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_PER_S;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_FILT   = 8'h08;
  localparam logic [7:0] A_START  = 8'h0C;
  localparam logic [7:0] A_HIGH   = 8'h10;
  localparam logic [7:0] A_CMP0   = 8'h14;
  localparam logic [7:0] A_CMP1   = 8'h18;
  localparam logic [7:0] A_UPD    = 8'h1C;
  localparam logic [7:0] A_POS    = 8'h20;
  localparam logic [7:0] A_STAT   = 8'h24;
  localparam logic [7:0] A_FREQ   = 8'h28;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int C_GATE   = 0;
  localparam int C_MOD    = 1;
  localparam int C_USEN   = 2;
  localparam int C_EXTREF = 3;
  localparam int C_FALL   = 4;
  localparam int C_CPUOK  = 5;
  localparam int C_MODE   = 6;
  localparam int C_USER1  = 8;
  localparam int K_SET1   = 0;
  localparam int K_SET2   = 1;
  localparam int K_ARM    = 2;
  localparam int S_OUT1   = 0;
  localparam int S_OUT2   = 1;
  localparam int S_ARMED  = 2;
  localparam int S_PEND   = 3;
  localparam int S_SPARE1 = 4;
  localparam int S_SPARE2 = 5;
  localparam int S_DIR    = 6;
  localparam logic [1:0] MODE_CMP = 2'h2;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [9:0]  CTRL_RST  = 10'h021;
  localparam logic [15:0] FILT_RST  = 16'(FILT_CYC);
  localparam logic [31:0] START_RST = 32'h0000_0000;
  localparam logic [31:0] LIN_HIGH  = 32'h7FFF_FFFF;
  localparam logic [31:0] LIN_LOW   = 32'h8000_0000;
  localparam logic [31:0] MOD_LOW   = 32'h0000_0000;
  localparam logic [31:0] CMP0_RST  = 32'h0000_0000;
  localparam logic [31:0] CMP1_RST  = 32'h0000_000A;
  localparam logic [7:0]  UPD_RST   = 8'(UPD_MS);
  localparam logic [7:0]  UPD_MAX   = 8'(UPD_MS_MAX);
endpackage : iepc_pkg

// ==== iepc_filter.sv ====
// iepc_filter: two-stage synchroniser plus stability filter for one pin.
// assumes limit is a quasi-static setting from the register file.
`timescale 1ns/1ps
`default_nettype none
module iepc_filter (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // pin and setting
  input  wire logic        raw,
  input  wire logic [15:0] limit,
  // filtered level
  output var  logic        filt
);
  logic        sync1;
  logic        sync2;
  logic [15:0] cnt;
  wire         differs = sync2 != filt;
  wire         settled = differs && (cnt >= limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // pulses shorter than limit cycles never reach filt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt <= 16'h0000;
    else if (!differs || settled) cnt <= 16'h0000;
    else cnt <= cnt + 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) filt <= 1'b0;
    else if (settled) filt <= sync2;
  end

  filter_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(filt) |-> $past(cnt) >= $past(limit) && $past(sync2) == filt)
    else $error("filter passed an unstable level");
endmodule : iepc_filter
`default_nettype wire

// ==== iepc_freq.sv ====
// iepc_freq: counts signed encoder steps over an update window.
// assumes one step pulse per decoded edge, from the same clock.
`timescale 1ns/1ps
`default_nettype none
module iepc_freq #(
  parameter int unsigned MS_CYC = iepc_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // steps and window
  input  wire logic        step,
  input  wire logic        up,
  input  wire logic [7:0]  upd_ms,
  // result
  output var  logic [31:0] freq
);
  logic [31:0] ms_cnt;
  logic [7:0]  win;
  logic [31:0] acc;
  wire         ms_tick = ms_cnt == 32'(MS_CYC - 1);
  // a zero window refreshes every millisecond
  wire         win_end = ms_tick && (win + 8'h01 >= upd_ms);
  wire  [31:0] delta   = !step ? 32'h0000_0000 : up ? 32'h0000_0001 : 32'hFFFF_FFFF;
  wire  [31:0] sum     = acc + delta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= 32'h0000_0000;
      win    <= 8'h00;
    end else begin
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
      if (win_end) win <= 8'h00;
      else if (ms_tick) win <= win + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc  <= 32'h0000_0000;
      freq <= 32'h0000_0000;
    end else if (win_end) begin
      acc  <= 32'h0000_0000;
      freq <= sum;
    end else begin
      acc  <= sum;
    end
  end

  freq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(win_end) |-> $stable(freq))
    else $error("measured value changed outside a window end");
endmodule : iepc_freq
`default_nettype wire

// ==== iepc_enc_model.sv ====
// iepc_enc_model: incremental encoder with tracks a, b and zero mark.
// assumes the bench calls its tasks one at a time from one process.
`timescale 1ns/1ps
`default_nettype none
module iepc_enc_model #(
  parameter int GAP = 12
) (
  // clock
  input  wire logic hclk,
  // encoder tracks
  output var  logic enc_a,
  output var  logic enc_b,
  output var  logic enc_n
);
  logic [1:0] ph;
  initial begin
    ph = 2'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_n = 1'b0;
  end
  // one quadrature edge; a leads b when up, edges GAP+1 cycles apart
  task automatic step(input bit up);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    @(posedge hclk);
    enc_a <= ph[1] ^ ph[0];
    enc_b <= ph[1];
    repeat (GAP) @(posedge hclk);
  endtask : step
  // short pulse on track a that must not count
  task automatic glitch(input int len);
    @(posedge hclk);
    enc_a <= ~enc_a;
    repeat (len) @(posedge hclk);
    enc_a <= ~enc_a;
    repeat (GAP) @(posedge hclk);
  endtask : glitch
  task automatic mark();
    @(posedge hclk);
    enc_n <= 1'b1;
    repeat (GAP) @(posedge hclk);
    enc_n <= 1'b0;
    repeat (GAP) @(posedge hclk);
  endtask : mark
endmodule : iepc_enc_model
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for the encoder position counter.
// assumes iepc_pkg, iepc_top and iepc_enc_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        enc_a;
  logic        enc_b;
  logic        enc_n;
  logic        reference_input = 1'b0;
  logic        spare_input_one = 1'b0;
  logic        spare_input_two = 1'b0;
  logic        first_compare_output;
  logic        second_compare_output;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] pos = 32'h0;
  logic [31:0] hi = iepc_pkg::LIN_HIGH;
  logic [31:0] rv;
  logic [31:0] rx [12] = '{32'h21, 32'h0, 32'h1F4, 32'h0, 32'h7FFFFFFF, 32'h0,
                           32'hA, 32'hA, 32'h0, 32'h0, 32'h0, 32'h0};
  bit          md = 1'b0;
  bit          gate = 1'b1;
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  iepc_top #(.MS_CYC(20)) u_iepc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .reference_input(reference_input),
    .spare_input_one(spare_input_one), .spare_input_two(spare_input_two),
    .first_compare_output(first_compare_output),
    .second_compare_output(second_compare_output));
  iepc_enc_model #(.GAP(12)) u_iepc_enc_model (.hclk(hclk), .enc_a(enc_a),
    .enc_b(enc_b), .enc_n(enc_n));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] p, input bit up);
    logic [31:0] lo;
    lo = md ? iepc_pkg::MOD_LOW : iepc_pkg::LIN_LOW;
    if (up) return (p == hi) ? lo : p + 32'h1;
    return (p == lo) ? hi : p - 32'h1;
  endfunction : nxt
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rv, exp);
  endtask : rdc
  task automatic mv(input int n, input bit up);
    repeat (n) begin
      u_iepc_enc_model.step(up);
      if (gate) pos = nxt(pos, up);
    end
  endtask : mv
  task automatic home(input logic [31:0] s);
    wr(iepc_pkg::A_START, s);
    wr(iepc_pkg::A_CMD, 32'h4);
    u_iepc_enc_model.mark();
    pos = s;
  endtask : home
  task automatic setref(input logic v);
    @(posedge hclk);
    reference_input <= v;
    repeat (16) @(posedge hclk);
  endtask : setref
  task automatic pins(input logic [1:0] exp);
    repeat (3) @(posedge hclk);
    check({30'h0, second_compare_output, first_compare_output}, {30'h0, exp});
  endtask : pins
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(70651));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      if (i != 9) check(rv, rx[i]);
    end
    wr(iepc_pkg::A_FILT, 32'h4);
    wr(iepc_pkg::A_UPD, 32'hC8);
    rdc(iepc_pkg::A_UPD, 32'h64);
    wr(iepc_pkg::A_UPD, 32'h2);
    wr(iepc_pkg::A_POS, 32'h55);
    rdc(iepc_pkg::A_POS, 32'h0);
    $display("test reset done");
    spare_input_one <= 1'($urandom);
    spare_input_two <= 1'($urandom);
    repeat (24) mv(1, 1'($urandom));
    rdc(iepc_pkg::A_POS, pos);
    bus(1'b0, iepc_pkg::A_STAT, 32'h0);
    check({30'h0, rv[5:4]}, {30'h0, spare_input_two, spare_input_one});
    u_iepc_enc_model.glitch(3);
    setref(1'b1);
    setref(1'b0);
    rdc(iepc_pkg::A_POS, pos);
    wr(iepc_pkg::A_CTRL, 32'h20);
    gate = 1'b0;
    mv(3, 1'b1);
    wr(iepc_pkg::A_CTRL, 32'h21);
    gate = 1'b1;
    mv(2, 1'b0);
    rdc(iepc_pkg::A_POS, pos);
    $display("test count done");
    wr(iepc_pkg::A_CTRL, 32'h25);
    home($urandom);
    rdc(iepc_pkg::A_POS, pos);
    mv(1, 1'b1);
    u_iepc_enc_model.mark();
    rdc(iepc_pkg::A_POS, pos);
    home(iepc_pkg::LIN_HIGH);
    mv(1, 1'b1);
    rdc(iepc_pkg::A_POS, iepc_pkg::LIN_LOW);
    mv(1, 1'b0);
    rdc(iepc_pkg::A_POS, iepc_pkg::LIN_HIGH);
    wr(iepc_pkg::A_HIGH, 32'h5);
    wr(iepc_pkg::A_CTRL, 32'h27);
    md = 1'b1;
    hi = 32'h5;
    home(32'h5);
    mv(1, 1'b1);
    rdc(iepc_pkg::A_POS, 32'h0);
    mv(1, 1'b0);
    rdc(iepc_pkg::A_POS, 32'h5);
    md = 1'b0;
    hi = iepc_pkg::LIN_HIGH;
    $display("test limits done");
    wr(iepc_pkg::A_CTRL, 32'h2D);
    wr(iepc_pkg::A_START, 32'h7);
    wr(iepc_pkg::A_CMD, 32'h4);
    setref(1'b1);
    rdc(iepc_pkg::A_POS, 32'h5);
    u_iepc_enc_model.mark();
    rdc(iepc_pkg::A_POS, 32'h7);
    setref(1'b0);
    wr(iepc_pkg::A_CTRL, 32'h39);
    wr(iepc_pkg::A_START, 32'h14);
    wr(iepc_pkg::A_CMD, 32'h4);
    setref(1'b1);
    rdc(iepc_pkg::A_POS, 32'h7);
    setref(1'b0);
    rdc(iepc_pkg::A_POS, 32'h14);
    pos = 32'h14;
    mv(1, 1'b1);
    setref(1'b1);
    setref(1'b0);
    rdc(iepc_pkg::A_POS, 32'h15);
    $display("test homing done");
    wr(iepc_pkg::A_CTRL, 32'hA5);
    home(32'h3);
    wr(iepc_pkg::A_CMD, 32'h3);
    pins(2'h3);
    mv(3, 1'b0);
    pins(2'h2);
    mv(9, 1'b1);
    pins(2'h2);
    mv(1, 1'b1);
    pins(2'h0);
    wr(iepc_pkg::A_CMD, 32'h2);
    wr(iepc_pkg::A_CTRL, 32'h81);
    pins(2'h0);
    wr(iepc_pkg::A_CTRL, 32'h121);
    pins(2'h3);
    wr(iepc_pkg::A_CTRL, 32'h21);
    pins(2'h2);
    $display("test compare done");
    fork
      mv(12, 1'b1);
      begin
        repeat (90) @(posedge hclk);
        bus(1'b0, iepc_pkg::A_FREQ, 32'h0);
        check(32'(rv >= 32'h2 && rv <= 32'h4), 32'h1);
      end
    join
    repeat (100) @(posedge hclk);
    rdc(iepc_pkg::A_FREQ, 32'h0);
    rdc(iepc_pkg::A_POS, pos);
    $display("test frequency done");
    close_out();
  end
endmodule : tb
`default_nettype wire
